//--- common/risc_core_pkg.sv
// Constants, carrier structs and state layout of the RISC operand/addressing core
package risc_core_pkg;
    // ****************************************
    // Instruction encoding: [15:12] op, [11:8] n, [7:4] m, [3:0] sub
    // ****************************************
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_ADD = 4'h1;
    localparam logic [3:0] OP_ADDI = 4'h2;
    localparam logic [3:0] OP_MOVI = 4'h3;
    localparam logic [3:0] OP_ANDI = 4'h4;
    localparam logic [3:0] OP_ORI = 4'h5;
    localparam logic [3:0] OP_TST = 4'h6;
    localparam logic [3:0] OP_CMPEQI = 4'h7;
    localparam logic [3:0] OP_CMPGE = 4'h8;
    localparam logic [3:0] OP_JT = 4'h9;
    localparam logic [3:0] OP_JF = 4'hA;
    localparam logic [3:0] OP_JMP = 4'hB;
    localparam logic [3:0] OP_LITW = 4'hC;
    localparam logic [3:0] OP_LITL = 4'hD;
    localparam logic [3:0] OP_MEM = 4'hE;
    localparam logic [3:0] OP_MUL = 4'hF;
    localparam logic [3:0] MS_MUL = 4'h0;
    localparam logic [3:0] MS_MAC = 4'h1;
    localparam logic [3:0] MS_RDL = 4'h2;
    localparam logic [3:0] MS_RDH = 4'h3;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] MD_IND = 2'h0;
    localparam logic [1:0] MD_POSTINC = 2'h1;
    localparam logic [1:0] MD_PREDEC = 2'h2;
    localparam logic [1:0] MD_INDEX = 2'h3;
    // ****************************************
    // Status word, pipeline and timing
    // ****************************************
    localparam int T_POS = 0;
    localparam logic [31:0] SR_RESET = 32'h000000F0;
    localparam logic [31:0] PC_AHEAD = 32'h00000004;
    localparam logic [1:0] MUL_CYCLES = 2'h2;
    localparam logic [1:0] MAC_CYCLES = 2'h3;
    localparam int MACH_W = 10;
    typedef enum logic [2:0] {ST_READY = 3'b001, ST_MEM = 3'b010, ST_MUL = 3'b100} fsm_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;
    typedef struct packed {
        logic valid;
        logic [3:0] idx;
        logic [31:0] data;
    } wb_t;
    typedef struct packed {
        fsm_t fsm;
        logic [15:0][31:0] gpr;
        logic [31:0] sr;
        logic [MACH_W-1:0] mach;
        logic [31:0] macl;
        logic [31:0] prod;
        logic [1:0] cnt;
        logic is_mac;
        mem_req_t mem;
        logic ld_en;
        logic [3:0] ld_idx;
        logic upd_en;
        logic [3:0] upd_idx;
        logic [31:0] upd_val;
        wb_t wb;
        logic jump_pending;
        logic [31:0] jump_target;
        logic redirect;
        logic [31:0] redirect_pc;
        logic addr_err;
        logic ready;
    } core_state_t;
    localparam core_state_t CORE_RESET = '{fsm: ST_READY, sr: SR_RESET, ready: 1'b1, default: '0};
endpackage

//--- hw/risc_operand_addressing_core.sv
// Decoder and datapath of the RISC operand/addressing core
`timescale 1ns/1ps
module risc_operand_addressing_core
    import risc_core_pkg::*;
(
    input wire logic sys_clk_in, // System clock, 25 MHz
    input wire logic reset_n_in, // Synchronous reset, active low
    input wire logic [15:0] instr_in, // Instruction word
    input wire logic [31:0] instr_pc_in, // Address of that instruction
    input wire logic instr_valid_in, // Instruction word valid
    output logic instr_ready_out, // Core takes an instruction
    input wire logic [31:0] mem_rdata_in, // Load data, low-aligned
    input wire logic mem_ack_in, // Memory access completes
    output mem_req_t mem_out, // Memory request
    output wb_t wb_out, // Register write-back report
    output logic redirect_out, // Fetch must restart
    output logic [31:0] redirect_pc_out, // Restart address
    output logic addr_err_out, // Misaligned access pulse
    output logic [31:0] state_word_out // State word, flag in bit 0
);
    core_state_t s, n;
    logic accept, done, wr_en, iss, iss_we, iss_upd;
    logic [3:0] op, rn, rm, sub, wr_idx, iss_upd_idx;
    logic [31:0] imm_s, imm_z, step, wr_val, iss_ea, iss_upd_val, ld_val;
    logic [1:0] msz, iss_sz;
    logic signed [15:0] mul_a, mul_b;
    logic [41:0] acc_sum;
    // Every assertion samples on the system clock and rests during reset
    default clocking core_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // ****************************************
    // Field extraction
    // ****************************************
    // Operand fields and immediates taken straight from the word
    assign accept = instr_valid_in && s.ready && (s.fsm == ST_READY);
    assign op = instr_in[15:12];
    assign rn = instr_in[11:8];
    assign rm = instr_in[7:4];
    assign sub = instr_in[3:0];
    assign imm_s = {{24{instr_in[7]}}, instr_in[7:0]};
    assign imm_z = {24'h000000, instr_in[7:0]};
    assign msz = (instr_in[1:0] == 2'h3) ? SZ_LONG : instr_in[1:0];
    assign step = 32'h00000001 << msz;
    assign mul_a = s.gpr[rn][15:0];
    assign mul_b = s.gpr[rm][15:0];
    assign acc_sum = {s.mach, s.macl} + {{10{s.prod[31]}}, s.prod};

    // Load data sign extension by access size
    assign ld_val = (s.mem.size == SZ_BYTE) ? {{24{mem_rdata_in[7]}}, mem_rdata_in[7:0]}
        : (s.mem.size == SZ_WORD) ? {{16{mem_rdata_in[15]}}, mem_rdata_in[15:0]}
        : mem_rdata_in;

    // ****************************************
    // Next-state logic
    // ****************************************
    // Decode, execute, memory wait and multiply wait
    always_comb begin
        n = s;
        n.wb.valid = 1'b0;
        n.redirect = 1'b0;
        n.addr_err = 1'b0;
        done = 1'b0;
        wr_en = 1'b0;
        wr_idx = rn;
        wr_val = 32'h00000000;
        iss = 1'b0;
        iss_we = 1'b0;
        iss_sz = msz;
        iss_ea = s.gpr[rm];
        iss_upd = 1'b0;
        iss_upd_idx = rm;
        iss_upd_val = s.gpr[rm] + step;
        case (s.fsm)
            ST_READY: begin
                n.ready = 1'b1;
                if (accept) begin
                    case (op)
                        OP_ADD: begin
                            wr_en = 1'b1;
                            wr_val = s.gpr[rn] + s.gpr[rm];
                            done = 1'b1;
                        end
                        OP_ADDI, OP_MOVI: begin
                            wr_en = 1'b1;
                            wr_val = (op == OP_ADDI) ? (s.gpr[rn] + imm_s) : imm_s;
                            done = 1'b1;
                        end
                        OP_ANDI, OP_ORI: begin
                            wr_en = 1'b1;
                            wr_idx = 4'h0;
                            wr_val = (op == OP_ANDI) ? (s.gpr[0] & imm_z) : (s.gpr[0] | imm_z);
                            done = 1'b1;
                        end
                        OP_TST: begin
                            n.sr[T_POS] = ((s.gpr[rn] & s.gpr[rm]) == 32'h00000000);
                            done = 1'b1;
                        end
                        OP_CMPEQI: begin
                            n.sr[T_POS] = (s.gpr[0] == imm_s);
                            done = 1'b1;
                        end
                        OP_CMPGE: begin
                            n.sr[T_POS] = ($signed(s.gpr[rn]) >= $signed(s.gpr[rm]));
                            done = 1'b1;
                        end
                        OP_JT, OP_JF: begin
                            // Taken purely from the flag; suppressed in a delay slot
                            if (!s.jump_pending && (s.sr[T_POS] == (op == OP_JT))) begin
                                n.redirect = 1'b1;
                                n.redirect_pc = instr_pc_in + PC_AHEAD
                                    + {{23{instr_in[7]}}, instr_in[7:0], 1'b0};
                            end
                            done = 1'b1;
                        end
                        OP_JMP: begin
                            if (!s.jump_pending) begin
                                n.jump_pending = 1'b1;
                                n.jump_target = instr_pc_in + PC_AHEAD
                                    + {{19{instr_in[11]}}, instr_in[11:0], 1'b0};
                            end else begin
                                done = 1'b1;
                            end
                        end
                        OP_LITW: begin
                            iss = 1'b1;
                            iss_sz = SZ_WORD;
                            iss_ea = instr_pc_in + PC_AHEAD + {23'h000000, instr_in[7:0], 1'b0};
                        end
                        OP_LITL: begin
                            iss = 1'b1;
                            iss_sz = SZ_LONG;
                            iss_ea = (instr_pc_in & 32'hFFFFFFFC) + PC_AHEAD
                                + {22'h000000, instr_in[7:0], 2'h0};
                        end
                        OP_MEM: begin
                            iss = 1'b1;
                            case (sub[3:2])
                                MD_POSTINC: iss_upd = 1'b1;
                                MD_PREDEC: begin
                                    iss_we = 1'b1;
                                    iss_ea = s.gpr[rn] - step;
                                    iss_upd = 1'b1;
                                    iss_upd_idx = rn;
                                    iss_upd_val = s.gpr[rn] - step;
                                end
                                MD_INDEX: iss_ea = s.gpr[0] + s.gpr[rm];
                                default: iss_ea = s.gpr[rm];
                            endcase
                        end
                        OP_MUL: begin
                            case (sub)
                                MS_MUL, MS_MAC: begin
                                    n.prod = mul_a * mul_b;
                                    n.is_mac = (sub == MS_MAC);
                                    n.cnt = ((sub == MS_MAC) ? MAC_CYCLES : MUL_CYCLES) - 2'h1;
                                    n.fsm = ST_MUL;
                                    n.ready = 1'b0;
                                end
                                MS_RDL, MS_RDH: begin
                                    wr_en = 1'b1;
                                    wr_val = (sub == MS_RDL) ? s.macl
                                        : {{22{s.mach[MACH_W-1]}}, s.mach};
                                    done = 1'b1;
                                end
                                default: done = 1'b1;
                            endcase
                        end
                        default: done = 1'b1;
                    endcase
                end
            end
            ST_MEM: begin
                if (mem_ack_in) begin
                    n.mem.req = 1'b0;
                    if (s.upd_en) begin
                        n.gpr[s.upd_idx] = s.upd_val;
                    end
                    wr_en = s.ld_en;
                    wr_idx = s.ld_idx;
                    wr_val = ld_val;
                    n.fsm = ST_READY;
                    n.ready = 1'b1;
                    done = 1'b1;
                end
            end
            ST_MUL: begin
                if (s.cnt == 2'h1) begin
                    {n.mach, n.macl} = s.is_mac ? acc_sum : {s.mach, s.prod};
                    n.fsm = ST_READY;
                    n.ready = 1'b1;
                    done = 1'b1;
                end else begin
                    n.cnt = s.cnt - 2'h1;
                end
            end
            default: begin
                n = CORE_RESET;
            end
        endcase
        // Start a memory access unless it is misaligned
        if (iss) begin
            if ((iss_sz == SZ_WORD && iss_ea[0]) || (iss_sz == SZ_LONG && iss_ea[1:0] != 2'h0)) begin
                n.addr_err = 1'b1;
                done = 1'b1;
            end else begin
                n.mem = '{req: 1'b1, we: iss_we, size: iss_sz, addr: iss_ea, wdata: s.gpr[rm]};
                n.ld_en = !iss_we;
                n.ld_idx = rn;
                n.upd_en = iss_upd;
                n.upd_idx = iss_upd_idx;
                n.upd_val = iss_upd_val;
                n.fsm = ST_MEM;
                n.ready = 1'b0;
            end
        end
        // Register write and its report
        if (wr_en) begin
            n.gpr[wr_idx] = wr_val;
            n.wb = '{valid: 1'b1, idx: wr_idx, data: wr_val};
        end
        // Delay-slot instruction finished: hand over to the jump target
        if (done && s.jump_pending) begin
            n.jump_pending = 1'b0;
            n.redirect = 1'b1;
            n.redirect_pc = s.jump_target;
        end
        n.ready = n.ready && !n.redirect;
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s <= CORE_RESET;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state
    assign instr_ready_out = s.ready;
    assign mem_out = s.mem;
    assign wb_out = s.wb;
    assign redirect_out = s.redirect;
    assign redirect_pc_out = s.redirect_pc;
    assign addr_err_out = s.addr_err;
    assign state_word_out = s.sr;

    // ****************************************
    // Assertions
    // ****************************************
    a_jump_delayed: assert property (accept && op == OP_JMP && !s.jump_pending
        |=> !s.redirect && s.jump_pending) else $error("jump taken before its delay slot");
    a_mul_latency: assert property (accept && op == OP_MUL && sub == MS_MUL
        |=> !s.ready ##1 s.ready && s.fsm == ST_READY) else $error("multiply latency wrong");
    a_mac_latency: assert property (accept && op == OP_MUL && sub == MS_MAC
        |=> !s.ready [*2] ##1 s.ready) else $error("multiply-accumulate latency wrong");
    a_flag_branch: assert property (accept && op == OP_JT && !s.jump_pending
        |=> s.redirect == $past(s.sr[T_POS])) else $error("jump-if-true disagrees with flag");
    a_add_keeps_flag: assert property (accept && (op == OP_ADD || op == OP_ADDI)
        |=> $stable(s.sr)) else $error("addition changed the flag");
    a_compare_signed_ge_flag: assert property (accept && op == OP_CMPGE |=>
        s.sr[T_POS] == ($signed($past(s.gpr[rn])) >= $signed($past(s.gpr[rm]))))
        else $error("signed compare flag wrong");
    a_test_zero_flag: assert property (accept && op == OP_TST |=>
        s.sr[T_POS] == (($past(s.gpr[rn]) & $past(s.gpr[rm])) == 32'h00000000))
        else $error("test flag wrong");
    a_imm_inline: assert property (accept && op == OP_MOVI |=> !s.mem.req
        && s.wb.valid && s.wb.data == $past(imm_s)) else $error("byte immediate not inline");
    a_align_error: assert property (s.mem.req |->
        !((s.mem.size == SZ_WORD && s.mem.addr[0]) || (s.mem.size == SZ_LONG
        && s.mem.addr[1:0] != 2'h0))) else $error("misaligned access issued");
endmodule

//--- bench/testbench.sv
// Self-checking bench for the RISC operand/addressing core
`timescale 1ns/1ps
module testbench;
    import risc_core_pkg::*;
    logic sys_clk_in;
    logic reset_n_in;
    logic [15:0] instr_in;
    logic [31:0] instr_pc_in;
    logic instr_valid_in;
    logic instr_ready_out;
    logic [31:0] mem_rdata_in;
    logic mem_ack_in;
    mem_req_t mem_out;
    wb_t wb_out;
    logic redirect_out;
    logic [31:0] redirect_pc_out;
    logic addr_err_out;
    logic [31:0] state_word_out;
    int mismatches;
    int n_compared;
    int cycles = 0;

    risc_operand_addressing_core risc_operand_addressing_core_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
        .instr_pc_in(instr_pc_in), .instr_valid_in(instr_valid_in),
        .instr_ready_out(instr_ready_out), .mem_rdata_in(mem_rdata_in),
        .mem_ack_in(mem_ack_in), .mem_out(mem_out), .wb_out(wb_out),
        .redirect_out(redirect_out), .redirect_pc_out(redirect_pc_out),
        .addr_err_out(addr_err_out), .state_word_out(state_word_out));

    // ****************************************
    // Clock, hang guard and shared tasks
    // ****************************************
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Cut a hang short well beyond the few hundred cycles the run needs
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    // Compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Present an instruction and hold it until the core takes it
    task automatic issue(input logic [15:0] word, input logic [31:0] pc);
        logic rdy;
        int n;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= word;
        instr_pc_in <= pc;
        n = 0;
        do begin
            @(negedge sys_clk_in);
            rdy = instr_ready_out;
            @(posedge sys_clk_in);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        chk("instruction taken", 32'h1, {31'h0, rdy});
        instr_valid_in <= 1'b0;
        instr_in <= ~word;
    endtask

    // Wait for a register write-back and judge it
    task automatic wait_wb(input logic [3:0] idx, input logic [31:0] data);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (wb_out.valid !== 1'b1 && n < 8);
        chk("write-back index", {27'h0, 1'b1, idx}, {27'h0, wb_out.valid, wb_out.idx});
        chk("write-back data", data, wb_out.data);
    endtask

    // Single-cycle instruction followed by its write-back
    task automatic run(input logic [15:0] word, input logic [3:0] idx, input logic [31:0] data);
        issue(word, 32'h0);
        wait_wb(idx, data);
    endtask

    // Answer one memory request after checking what it asks for
    task automatic mem_serve(input logic we, input logic [1:0] size, input logic [31:0] addr,
                             input logic [31:0] data);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (mem_out.req !== 1'b1 && n < 8);
        chk("request kind", {28'h1, we, 1'b0, size},
            {27'h0, mem_out.req, mem_out.we, 1'b0, mem_out.size});
        chk("request address", addr, mem_out.addr);
        if (we) chk("store data", data, mem_out.wdata);
        @(posedge sys_clk_in);
        mem_ack_in <= 1'b1;
        mem_rdata_in <= data;
        @(posedge sys_clk_in);
        mem_ack_in <= 1'b0;
        mem_rdata_in <= ~data;
    endtask

    // Watch three cycles for a fetch restart
    task automatic expect_redir(input logic exp, input logic [31:0] target);
        logic seen;
        logic [31:0] pcv;
        seen = 1'b0;
        pcv = '0;
        repeat (3) begin
            @(negedge sys_clk_in);
            if (redirect_out !== 1'b0) begin
                seen = 1'b1;
                pcv = redirect_pc_out;
            end
        end
        chk("redirect", {31'h0, exp}, {31'h0, seen});
        if (exp) chk("redirect target", target, pcv);
    endtask

    // Issue and judge the condition flag one cycle later
    task automatic flag_op(input logic [15:0] word, input logic exp);
        issue(word, 32'h0);
        @(negedge sys_clk_in);
        chk("condition flag", {31'h0, exp}, {31'h0, state_word_out[T_POS]});
    endtask

    // Count the busy cycles of a multiplier operation
    task automatic mul_time(input logic [15:0] word, input int lo, input int hi);
        int n;
        issue(word, 32'h0);
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (instr_ready_out !== 1'b1 && n < 8);
        n_compared++;
        if (n - 1 < lo || n - 1 > hi) begin
            mismatches++;
            $display("unexpected multiply busy cycles: expected %0d to %0d, seen %0d", lo, hi, n - 1);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Byte immediates, extension of each kind, flag setting and conditional jumps
    task automatic test_imm_flag();
        run({OP_MOVI, 4'h0, 8'h80}, 4'h0, 32'hFFFFFF80);
        run({OP_ANDI, 4'h0, 8'hF0}, 4'h0, 32'h00000080);
        run({OP_ORI, 4'h0, 8'h81}, 4'h0, 32'h00000081);
        run({OP_ADDI, 4'h0, 8'hFF}, 4'h0, 32'h00000080);
        run({OP_MOVI, 4'h1, 8'hFD}, 4'h1, 32'hFFFFFFFD);
        run({OP_MOVI, 4'h2, 8'h07}, 4'h2, 32'h00000007);
        run({OP_MOVI, 4'h3, 8'h02}, 4'h3, 32'h00000002);
        flag_op({OP_TST, 4'h1, 4'h3, 4'h0}, 1'b1);
        issue({OP_JT, 4'h0, 8'h01}, 32'h600);
        expect_redir(1'b1, 32'h00000606);
        run({OP_ADD, 4'h3, 4'h1, 4'h0}, 4'h3, 32'hFFFFFFFF);
        flag_op({OP_NOP, 12'h000}, 1'b1);
        flag_op({OP_CMPEQI, 4'h0, 8'h80}, 1'b0);
        flag_op({OP_TST, 4'h1, 4'h2, 4'h0}, 1'b0);
        flag_op({OP_CMPGE, 4'h2, 4'h1, 4'h0}, 1'b1);
        issue({OP_JT, 4'h0, 8'h10}, 32'h400);
        expect_redir(1'b1, 32'h00000424);
        issue({OP_JF, 4'h0, 8'h10}, 32'h424);
        expect_redir(1'b0, 32'h0);
        flag_op({OP_CMPGE, 4'h1, 4'h2, 4'h0}, 1'b0);
        issue({OP_JF, 4'h0, 8'hF0}, 32'h500);
        expect_redir(1'b1, 32'h000004E4);
        issue({OP_JT, 4'h0, 8'h10}, 32'h500);
        expect_redir(1'b0, 32'h0);
    endtask

    // Delayed jump whose slot adds, then multiply and accumulate
    task automatic test_jump_mul();
        issue({OP_JMP, 12'h010}, 32'h100);
        expect_redir(1'b0, 32'h0);
        issue({OP_ADD, 4'h2, 4'h1, 4'h0}, 32'h102);
        wait_wb(4'h2, 32'h00000004);
        chk("jump after slot", 32'h1, {31'h0, redirect_out});
        chk("jump target", 32'h00000124, redirect_pc_out);
        mul_time({OP_MUL, 4'h1, 4'h2, MS_MUL}, 1, 3);
        run({OP_MUL, 4'h4, 4'h0, MS_RDL}, 4'h4, 32'hFFFFFFF4);
        mul_time({OP_MUL, 4'h1, 4'h2, MS_MAC}, 2, 3);
        run({OP_MUL, 4'h4, 4'h0, MS_RDL}, 4'h4, 32'hFFFFFFE8);
        run({OP_MUL, 4'h4, 4'h0, MS_RDH}, 4'h4, 32'h00000000);
    endtask

    // Literal loads and every addressing mode, in order of pointer movement
    task automatic test_modes();
        logic [1:0] sz [3] = '{SZ_LONG, SZ_WORD, SZ_BYTE};
        logic [31:0] step [3] = '{32'h4, 32'h2, 32'h1};
        logic [31:0] dat [3] = '{32'h80000001, 32'h00008002, 32'h00000083};
        logic [31:0] ext [3] = '{32'h80000001, 32'hFFFF8002, 32'hFFFFFF83};
        logic [31:0] a;
        logic err;
        logic req;
        issue({OP_LITW, 4'h4, 8'h03}, 32'h200);
        mem_serve(1'b0, SZ_WORD, 32'h0000020A, 32'h00008001);
        wait_wb(4'h4, 32'hFFFF8001);
        issue({OP_LITL, 4'h5, 8'h02}, 32'h202);
        mem_serve(1'b0, SZ_LONG, 32'h0000020C, 32'h00001000);
        wait_wb(4'h5, 32'h00001000);
        a = 32'h00001000;
        for (int i = 0; i < 3; i++) begin
            issue({OP_MEM, 4'h6, 4'h5, MD_IND, SZ_BYTE}, 32'h0);
            mem_serve(1'b0, SZ_BYTE, a, 32'h000000F3);
            wait_wb(4'h6, 32'hFFFFFFF3);
            if (i < 2) begin
                issue({OP_MEM, 4'h6, 4'h5, MD_POSTINC, sz[i]}, 32'h0);
                mem_serve(1'b0, sz[i], a, dat[i]);
                wait_wb(4'h6, ext[i]);
                a = a + step[i];
            end
        end
        issue({OP_MEM, 4'h6, 4'h5, MD_POSTINC, SZ_BYTE}, 32'h0);
        mem_serve(1'b0, SZ_BYTE, a, 32'h0000007F);
        wait_wb(4'h6, 32'h0000007F);
        a = a + 32'h1;
        for (int i = 0; i < 2; i++) begin
            issue({OP_MEM, 4'h6, 4'h5, MD_IND, sz[i]}, 32'h0);
            err = 1'b0;
            req = 1'b0;
            repeat (3) begin
                @(negedge sys_clk_in);
                err = err | (addr_err_out === 1'b1);
                req = req | (mem_out.req !== 1'b0);
            end
            chk("address error", 32'h1, {31'h0, err});
            chk("misaligned request", 32'h0, {31'h0, req});
        end
        for (int i = 2; i >= 0; i--) begin
            a = a - step[i];
            issue({OP_MEM, 4'h5, 4'h6, MD_PREDEC, sz[i]}, 32'h0);
            mem_serve(1'b1, sz[i], a, 32'h0000007F);
        end
        issue({OP_LITW, 4'h0, 8'h00}, 32'h300);
        mem_serve(1'b0, SZ_WORD, 32'h00000304, 32'h00000010);
        wait_wb(4'h0, 32'h00000010);
        issue({OP_MEM, 4'h7, 4'h5, MD_INDEX, SZ_LONG}, 32'h0);
        mem_serve(1'b0, SZ_LONG, 32'h00001010, 32'h5A5A0001);
        wait_wb(4'h7, 32'h5A5A0001);
    endtask

    // Print the counts and the verdict, then stop
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: reset for 16 cycles, then every scenario
    initial begin
        mismatches = 0;
        n_compared = 0;
        reset_n_in = 1'b0;
        instr_in = '0;
        instr_pc_in = '0;
        instr_valid_in = 1'b0;
        mem_rdata_in = '0;
        mem_ack_in = 1'b0;
        repeat (16) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        @(negedge sys_clk_in);
        chk("state word after reset", SR_RESET, state_word_out);
        test_imm_flag();
        test_jump_mul();
        test_modes();
        final_report();
    end
endmodule
